// *** hw/psm_defines.svh ***
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

// maintenance command identifiers (16-bit parameter ids)
`define PSM_ID_ALARM_RESET        16'h00c0
`define PSM_ID_ALARM_LOG_CLEAR    16'h00c2
`define PSM_ID_POSITION_PRESET    16'h00c5
`define PSM_ID_APPLY_CONFIG       16'h00c6
`define PSM_ID_DEFAULTS_KEEP_COMM 16'h00c7
`define PSM_ID_NV_LOAD_ALL        16'h00c8
`define PSM_ID_NV_SAVE_ALL        16'h00c9
`define PSM_ID_DEFAULTS_ALL       16'h00ca
`define PSM_ID_RESTORE_SPARE      16'h00cb
`define PSM_ID_SAVE_SPARE         16'h00cc
`define PSM_ID_LATCH_INFO_CLEAR   16'h00cd
`define PSM_ID_SEQ_LOG_CLEAR      16'h00ce
`define PSM_ID_TRIP_CLEAR         16'h00cf
`define PSM_ID_DEENERGIZE_CLEAR   16'h00d0
`define PSM_ID_HOME_PRESET        16'h00d1
`define PSM_ID_HOME_PRESET_CLEAR  16'h00d2
`define PSM_ID_NOTICE_CLEAR       16'h00d3
`define PSM_ID_NOTICE_LOG_CLEAR   16'h00d4
`define PSM_ID_DETAIL_SELECT      16'h00d5

// history-detail selector range and reset value
`define PSM_DETAIL_MAX            32'h0000000a
`define PSM_DETAIL_RESET          32'h00000000

// id of the first parameter slot in the working store
`define PSM_PARAM_BASE            16'h0100

// cycles the link stays down while configuration runs
`define PSM_CFG_HOLD_CYCLES       16

`endif

// *** hw/psm_pkg.sv ***
package psm_pkg;

   // update-timing class of a parameter
   typedef enum logic [1:0] {
      PSM_CLS_A = 2'h0,
      PSM_CLS_B = 2'h1,
      PSM_CLS_C = 2'h2,
      PSM_CLS_D = 2'h3
   } psm_class_e;

   // controller states, one-hot
   typedef enum logic [3:0] {
      PSM_BOOT_LOAD  = 4'h1,
      PSM_BOOT_APPLY = 4'h2,
      PSM_IDLE       = 4'h4,
      PSM_CONFIG     = 4'h8
   } psm_state_e;

   // one write from the cyclic link
   typedef struct packed {
      logic        valid;
      logic [15:0] id;
      logic [31:0] data;
   } psm_write_s;

   // one-cycle action strobes to the rest of the driver
   typedef struct packed {
      logic alarm_reset;
      logic alarm_log_clear;
      logic position_preset;
      logic restore_from_spare;
      logic save_to_spare;
      logic latch_info_clear;
      logic sequence_log_clear;
      logic trip_distance_clear;
      logic deenergize_clear;
      logic home_sensor_preset;
      logic home_sensor_preset_clear;
      logic notice_clear;
      logic notice_log_clear;
   } psm_action_s;

endpackage : psm_pkg

// *** hw/psm_param_slot.sv ***
`timescale 1ns/1ps
`default_nettype none

module psm_param_slot #(
   parameter psm_pkg::psm_class_e CLS     = psm_pkg::PSM_CLS_A,
   parameter logic [31:0]         DEFAULT = 32'h00000000,
   parameter bit                  IS_COMM = 1'b0
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // store control
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   input  wire logic        load_nv,
   input  wire logic        save_nv,
   input  wire logic        def_all,
   input  wire logic        def_keep,
   // apply events
   input  wire logic        motion_stopped,
   input  wire logic        cfg_apply,
   input  wire logic        boot_apply,
   // values
   output logic      [31:0] work,
   output logic      [31:0] applied
);

   logic [31:0] nv = DEFAULT;   // factory content until the first save
   logic        dirty;
   logic        change;
   logic        apply_now;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   // any event that alters the working copy
   always_comb change = wr_en | load_nv | def_all | (def_keep & ~IS_COMM);

   // when the working copy becomes the value in use
   always_comb
   begin
      apply_now = boot_apply;
      if (CLS == psm_pkg::PSM_CLS_A && dirty)
         apply_now = 1'b1;
      if (CLS == psm_pkg::PSM_CLS_B && dirty && motion_stopped)
         apply_now = 1'b1;
      if (CLS == psm_pkg::PSM_CLS_C && cfg_apply)
         apply_now = 1'b1;
   end

   // working copy, cleared by control power reset
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         work <= 32'h00000000;
      else if (wr_en)
         work <= wr_data;
      else if (load_nv)
         work <= nv;
      else if (def_all || (def_keep && !IS_COMM))
         work <= DEFAULT;
   end

   // non-volatile copy, no reset so it survives power loss
   always_ff @(posedge clock)
   begin
      if (save_nv)
         nv <= work;
   end

   // pending flag, a new change wins over the apply
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         dirty <= 1'b0;
      else if (change)
         dirty <= 1'b1;
      else if (apply_now)
         dirty <= 1'b0;
   end

   // value in use by the driver
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         applied <= 32'h00000000;
      else if (apply_now)
         applied <= work;
   end

   property p_nv_untouched;
      wr_en && !save_nv |=> $stable(nv);
   endproperty
   a_nv_untouched: assert property (p_nv_untouched)
      else $error("link write altered the non-volatile copy");

   property p_nv_save;
      save_nv |=> nv == $past(work);
   endproperty
   a_nv_save: assert property (p_nv_save)
      else $error("save did not copy working value");

   property p_nv_load;
      load_nv && !wr_en |=> work == $past(nv);
   endproperty
   a_nv_load: assert property (p_nv_load)
      else $error("load did not copy non-volatile value");

   property p_keep_comm;
      IS_COMM && def_keep && !def_all && !wr_en && !load_nv
         |=> $stable(work);
   endproperty
   a_keep_comm: assert property (p_keep_comm)
      else $error("partial defaults touched a comm setting");

   property p_class_a;
      CLS == psm_pkg::PSM_CLS_A && wr_en |=> ##1 applied == $past(wr_data, 2);
   endproperty
   a_class_a: assert property (p_class_a)
      else $error("class A value not applied after write");

   property p_class_b;
      CLS == psm_pkg::PSM_CLS_B && !motion_stopped && !boot_apply
         |=> $stable(applied);
   endproperty
   a_class_b: assert property (p_class_b)
      else $error("class B value applied while moving");

   property p_class_c;
      CLS == psm_pkg::PSM_CLS_C && !cfg_apply && !boot_apply
         |=> $stable(applied);
   endproperty
   a_class_c: assert property (p_class_c)
      else $error("class C value applied without configuration");

   property p_class_d;
      CLS == psm_pkg::PSM_CLS_D && !boot_apply |=> $stable(applied);
   endproperty
   a_class_d: assert property (p_class_d)
      else $error("class D value applied without power cycle");

endmodule : psm_param_slot

`default_nettype wire

// *** hw/psm_param_store.sv ***
//////////////////////////////////////////////////////////////////////////////
// Contract
// - every parameter and data item is held and exchanged as 32 bits
// - working store is lost at power removal, non-volatile store is kept
// - at power-up copy non-volatile to working store, then apply all
// - link parameter writes change only the working store
// - save command copies the whole working store to non-volatile memory
// - class A values apply as soon as the write is taken
// - class B values wait until motor operation has stopped
// - class C values wait for configuration or a power cycle
// - class D values wait for a power cycle only
// - two defaults commands, one keeping and one resetting comm settings
// - load command reloads working store from non-volatile memory
// - alarm reset and latch clear each have their own command id
// - history-detail selector takes 1 to 10, zero means none, resets zero
// - configuration drops the cyclic link and restores it when done
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "psm_defines.svh"

module psm_param_store #(
   parameter int                        NUM_PARAMS  = 4,
   parameter logic [NUM_PARAMS*2-1:0]   PARAM_CLASS = 8'b11_10_01_00,
   parameter logic [NUM_PARAMS*32-1:0]  PARAM_INIT  = '0,
   parameter logic [NUM_PARAMS-1:0]     PARAM_COMM  = 4'b1000
) (
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst_b,
   // cyclic link writes
   input  wire psm_pkg::psm_write_s      wr,
   output logic                          wr_ack,
   // readback
   input  wire logic                     rd_valid,
   input  wire logic [15:0]              rd_id,
   output logic [31:0]                   rd_data,
   output logic                          rd_ack,
   // motor status
   input  wire logic                     motion_stopped,
   // status and actions
   output logic                          link_up,
   output logic                          busy,
   output psm_pkg::psm_action_s          actions,
   output logic [31:0]                   detail_select,
   output logic [NUM_PARAMS*32-1:0]      applied_params
);

   localparam int IW       = (NUM_PARAMS > 1) ? $clog2(NUM_PARAMS) : 1;
   localparam int CW       = $clog2(`PSM_CFG_HOLD_CYCLES + 1);
   localparam int CFG_WAIT = `PSM_CFG_HOLD_CYCLES + 2;

   psm_pkg::psm_state_e state;
   psm_pkg::psm_state_e next_state;
   logic [CW-1:0]       cfg_cnt;
   logic                acc;
   logic [15:0]         wr_idx;
   logic [15:0]         rd_idx;
   logic                wr_hit;
   logic                rd_hit;
   logic                known_cmd;
   logic                load_nv;
   logic                save_nv;
   logic                def_all;
   logic                def_keep;
   logic                cfg_apply;
   logic                boot_apply;
   logic [31:0]         work_q [NUM_PARAMS];

   //////////////////////////////////////////////////////////////////////////
   // request decode

   // a write is taken only while idle with the link up
   always_comb acc = wr.valid && link_up && state == psm_pkg::PSM_IDLE;

   // parameter slot hit tests
   always_comb
   begin
      wr_idx = wr.id - `PSM_PARAM_BASE;
      rd_idx = rd_id - `PSM_PARAM_BASE;
      wr_hit = wr.id >= `PSM_PARAM_BASE && wr_idx < 16'(NUM_PARAMS);
      rd_hit = rd_id >= `PSM_PARAM_BASE && rd_idx < 16'(NUM_PARAMS);
   end

   // ids of the maintenance set
   always_comb
   begin
      case (wr.id)
         `PSM_ID_ALARM_RESET, `PSM_ID_ALARM_LOG_CLEAR,
         `PSM_ID_POSITION_PRESET, `PSM_ID_APPLY_CONFIG,
         `PSM_ID_DEFAULTS_KEEP_COMM, `PSM_ID_NV_LOAD_ALL,
         `PSM_ID_NV_SAVE_ALL, `PSM_ID_DEFAULTS_ALL,
         `PSM_ID_RESTORE_SPARE, `PSM_ID_SAVE_SPARE,
         `PSM_ID_LATCH_INFO_CLEAR, `PSM_ID_SEQ_LOG_CLEAR,
         `PSM_ID_TRIP_CLEAR, `PSM_ID_DEENERGIZE_CLEAR,
         `PSM_ID_HOME_PRESET, `PSM_ID_HOME_PRESET_CLEAR,
         `PSM_ID_NOTICE_CLEAR, `PSM_ID_NOTICE_LOG_CLEAR,
         `PSM_ID_DETAIL_SELECT:
            known_cmd = 1'b1;
         default:
            known_cmd = 1'b0;
      endcase
   end

   // store-wide strobes, data value is ignored
   always_comb
   begin
      load_nv    = state == psm_pkg::PSM_BOOT_LOAD ||
                   (acc && wr.id == `PSM_ID_NV_LOAD_ALL);
      save_nv    = acc && wr.id == `PSM_ID_NV_SAVE_ALL;
      def_all    = acc && wr.id == `PSM_ID_DEFAULTS_ALL;
      def_keep   = acc && wr.id == `PSM_ID_DEFAULTS_KEEP_COMM;
      boot_apply = state == psm_pkg::PSM_BOOT_APPLY;
      cfg_apply  = state == psm_pkg::PSM_CONFIG && cfg_cnt == '0;
   end

   //////////////////////////////////////////////////////////////////////////
   // controller

   // boot copy, boot apply, idle and configuration
   always_comb
   begin
      case (state)
         psm_pkg::PSM_BOOT_LOAD:
            next_state = psm_pkg::PSM_BOOT_APPLY;
         psm_pkg::PSM_BOOT_APPLY:
            next_state = psm_pkg::PSM_IDLE;
         psm_pkg::PSM_IDLE:
            if (acc && wr.id == `PSM_ID_APPLY_CONFIG)
               next_state = psm_pkg::PSM_CONFIG;
            else
               next_state = psm_pkg::PSM_IDLE;
         psm_pkg::PSM_CONFIG:
            if (cfg_cnt == '0)
               next_state = psm_pkg::PSM_IDLE;
            else
               next_state = psm_pkg::PSM_CONFIG;
         default:
            next_state = psm_pkg::PSM_BOOT_LOAD;
      endcase
   end

   // state register, power-up starts with the boot copy
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         state <= psm_pkg::PSM_BOOT_LOAD;
      else
         state <= next_state;
   end

   // configuration hold counter
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         cfg_cnt <= '0;
      else if (next_state == psm_pkg::PSM_CONFIG &&
               state != psm_pkg::PSM_CONFIG)
         cfg_cnt <= CW'(`PSM_CFG_HOLD_CYCLES - 1);
      else if (cfg_cnt != '0)
         cfg_cnt <= cfg_cnt - 1'b1;
   end

   // cyclic link is down during boot and configuration
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         link_up <= 1'b0;
      else
         link_up <= next_state == psm_pkg::PSM_IDLE;
   end

   // busy mirrors every non-idle state
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         busy <= 1'b1;
      else
         busy <= next_state != psm_pkg::PSM_IDLE;
   end

   //////////////////////////////////////////////////////////////////////////
   // maintenance actions

   // one strobe per accepted action command write
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         actions <= '0;
      else
      begin
         actions <= '0;
         if (acc)
         begin
            case (wr.id)
               `PSM_ID_ALARM_RESET:       actions.alarm_reset <= 1'b1;
               `PSM_ID_ALARM_LOG_CLEAR:   actions.alarm_log_clear <= 1'b1;
               `PSM_ID_POSITION_PRESET:   actions.position_preset <= 1'b1;
               `PSM_ID_RESTORE_SPARE:
                  actions.restore_from_spare <= 1'b1;
               `PSM_ID_SAVE_SPARE:        actions.save_to_spare <= 1'b1;
               `PSM_ID_LATCH_INFO_CLEAR:
                  actions.latch_info_clear <= 1'b1;
               `PSM_ID_SEQ_LOG_CLEAR:
                  actions.sequence_log_clear <= 1'b1;
               `PSM_ID_TRIP_CLEAR:
                  actions.trip_distance_clear <= 1'b1;
               `PSM_ID_DEENERGIZE_CLEAR:
                  actions.deenergize_clear <= 1'b1;
               `PSM_ID_HOME_PRESET:
                  actions.home_sensor_preset <= 1'b1;
               `PSM_ID_HOME_PRESET_CLEAR:
                  actions.home_sensor_preset_clear <= 1'b1;
               `PSM_ID_NOTICE_CLEAR:      actions.notice_clear <= 1'b1;
               `PSM_ID_NOTICE_LOG_CLEAR:  actions.notice_log_clear <= 1'b1;
               default:                   actions <= '0;
            endcase
         end
      end
   end

   // history-detail selector, out-of-range values are dropped
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         detail_select <= `PSM_DETAIL_RESET;
      else if (acc && wr.id == `PSM_ID_DETAIL_SELECT &&
               wr.data <= `PSM_DETAIL_MAX)
         detail_select <= wr.data;
   end

   // acknowledge every taken write, known or not
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         wr_ack <= 1'b0;
      else
         wr_ack <= acc;
   end

   //////////////////////////////////////////////////////////////////////////
   // parameter slots

   // one slot per parameter, class fixed at build time
   for (genvar i = 0; i < NUM_PARAMS; i++)
   begin : g_slot
      psm_param_slot #(
         .CLS     (psm_pkg::psm_class_e'(PARAM_CLASS[2*i +: 2])),
         .DEFAULT (PARAM_INIT[32*i +: 32]),
         .IS_COMM (PARAM_COMM[i])
      ) u_slot (
         .clock          (clock),
         .rst_b          (rst_b),
         .wr_en          (acc && wr_hit && wr_idx[IW-1:0] == IW'(i)),
         .wr_data        (wr.data),
         .load_nv        (load_nv),
         .save_nv        (save_nv),
         .def_all        (def_all),
         .def_keep       (def_keep),
         .motion_stopped (motion_stopped),
         .cfg_apply      (cfg_apply),
         .boot_apply     (boot_apply),
         .work           (work_q[i]),
         .applied        (applied_params[32*i +: 32])
      );
   end

   //////////////////////////////////////////////////////////////////////////
   // readback

   // working value or selector, zero elsewhere
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_data <= 32'h00000000;
         rd_ack  <= 1'b0;
      end
      else
      begin
         rd_ack <= rd_valid;
         if (rd_valid && rd_id == `PSM_ID_DETAIL_SELECT)
            rd_data <= detail_select;
         else if (rd_valid && rd_hit)
            rd_data <= work_q[rd_idx[IW-1:0]];
         else
            rd_data <= 32'h00000000;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_boot;
      state == psm_pkg::PSM_BOOT_APPLY ##1 state == psm_pkg::PSM_IDLE;
   endsequence

   property p_boot;
      @(posedge clock) disable iff (!rst_b)
      state == psm_pkg::PSM_BOOT_LOAD |=> s_boot ##1 link_up;
   endproperty
   a_boot: assert property (p_boot)
      else $error("boot copy and apply did not complete");

   sequence s_cfg_start;
      acc && wr.id == `PSM_ID_APPLY_CONFIG;
   endsequence

   property p_cfg_drop;
      @(posedge clock) disable iff (!rst_b)
      s_cfg_start |=> !link_up [*2];
   endproperty
   a_cfg_drop: assert property (p_cfg_drop)
      else $error("link stayed up during configuration");

   property p_cfg_resume;
      @(posedge clock) disable iff (!rst_b)
      s_cfg_start |-> ##[2:CFG_WAIT] link_up;
   endproperty
   a_cfg_resume: assert property (p_cfg_resume)
      else $error("link not restored after configuration");

   property p_alarm_once;
      @(posedge clock) disable iff (!rst_b)
      acc && wr.id == `PSM_ID_ALARM_RESET
         ##1 !(acc && wr.id == `PSM_ID_ALARM_RESET)
         |-> actions.alarm_reset ##1 !actions.alarm_reset;
   endproperty
   a_alarm_once: assert property (p_alarm_once)
      else $error("alarm reset strobe not a single pulse");

   property p_latch_clear;
      @(posedge clock) disable iff (!rst_b)
      acc && wr.id == `PSM_ID_LATCH_INFO_CLEAR |=> actions.latch_info_clear;
   endproperty
   a_latch_clear: assert property (p_latch_clear)
      else $error("latch clear strobe missing");

   property p_unknown;
      @(posedge clock) disable iff (!rst_b)
      acc && !known_cmd && !wr_hit
         |=> actions == '0 && $stable(detail_select) && link_up;
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("unknown id caused an effect");

   property p_detail_range;
      @(posedge clock) disable iff (!rst_b)
      detail_select <= `PSM_DETAIL_MAX;
   endproperty
   a_detail_range: assert property (p_detail_range)
      else $error("selector left its range");

   property p_detail_write;
      @(posedge clock) disable iff (!rst_b)
      acc && wr.id == `PSM_ID_DETAIL_SELECT && wr.data <= `PSM_DETAIL_MAX
         |=> detail_select == $past(wr.data);
   endproperty
   a_detail_write: assert property (p_detail_write)
      else $error("selector write not stored");

endmodule : psm_param_store

`default_nettype wire

// *** tb/psm_scanner.sv ***
`timescale 1ns/1ps
`default_nettype none

module psm_scanner (
   // clock
   input  wire logic           clock,
   // requests to the store
   output psm_pkg::psm_write_s wr,
   output logic                rd_valid,
   output logic [15:0]         rd_id,
   // answers from the store
   input  wire logic           wr_ack,
   input  wire logic           rd_ack,
   input  wire logic [31:0]    rd_data,
   input  wire logic           link_up
);
   int n;

   // idle request lines
   initial
   begin
      wr       = '0;
      rd_valid = 1'b0;
      rd_id    = 16'h0000;
   end

   //////////////////////////////////////////////////////////////
   // one 32-bit write, saves only as a scenario needs them
   task automatic write(input logic [15:0] id, input logic [31:0] d,
                        output logic ok);
      n = 0;
      while (link_up !== 1'b1 && n < 100)
      begin
         @(posedge clock);
         n++;
      end
      @(posedge clock);
      wr <= '{1'b1, id, d};
      @(posedge clock);
      wr <= '{1'b0, ~id, ~d}; // released lines change
      #1;
      ok = wr_ack;
   endtask : write

   // one read, answered one cycle later
   task automatic read(input logic [15:0] id, output logic ok,
                       output logic [31:0] q);
      @(posedge clock);
      rd_valid <= 1'b1;
      rd_id    <= id;
      @(posedge clock);
      rd_valid <= 1'b0;
      rd_id    <= ~id;
      #1;
      ok = rd_ack;
      q  = rd_data;
   endtask : read
endmodule : psm_scanner

`default_nettype wire

// *** tb/psm_param_store_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module psm_param_store_tb;
   logic                clock = 1'b0;
   logic                rst_b = 1'b0;
   logic                motion_stopped = 1'b0;
   psm_pkg::psm_write_s wr;
   psm_pkg::psm_action_s actions;
   logic                wr_ack, rd_valid, rd_ack, link_up, busy, ok;
   logic [15:0]         rd_id;
   logic [31:0]         rd_data, detail_select, q;
   logic [127:0]        applied_params;
   int                  n_errors = 0;
   int                  samples_checked = 0;
   logic [15:0]         cmds [13] = '{16'h00c0, 16'h00c2, 16'h00c5,
      16'h00cb, 16'h00cc, 16'h00cd, 16'h00ce, 16'h00cf, 16'h00d0,
      16'h00d1, 16'h00d2, 16'h00d3, 16'h00d4};

   // clock of 50 ns
   always #25 clock = ~clock;

   psm_param_store i_psm_param_store (.clock(clock), .rst_b(rst_b),
      .wr(wr), .wr_ack(wr_ack), .rd_valid(rd_valid), .rd_id(rd_id),
      .rd_data(rd_data), .rd_ack(rd_ack),
      .motion_stopped(motion_stopped), .link_up(link_up), .busy(busy),
      .actions(actions), .detail_select(detail_select),
      .applied_params(applied_params));

   psm_scanner i_psm_scanner (.clock(clock), .wr(wr),
      .rd_valid(rd_valid), .rd_id(rd_id), .wr_ack(wr_ack),
      .rd_ack(rd_ack), .rd_data(rd_data), .link_up(link_up));

   //////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // write and expect acknowledge
   task automatic wrt(input logic [15:0] id, input logic [31:0] d);
      i_psm_scanner.write(id, d, ok);
      chk({31'h0, ok}, 32'h1);
   endtask : wrt

   // read and compare
   task automatic rdc(input logic [15:0] id, input logic [31:0] exp);
      i_psm_scanner.read(id, ok, q);
      chk({31'h0, ok}, 32'h1);
      chk(q, exp);
   endtask : rdc

   function automatic logic [31:0] slot(input int i);
      return applied_params[32*i +: 32];
   endfunction : slot

   // power cycle, then wait for boot to end
   task automatic pwr;
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      repeat (4) @(posedge clock);
      #1;
      chk({31'h0, link_up}, 32'h1);
   endtask : pwr

   // defaults saved, then booted from them
   task automatic t_boot;
      pwr();
      chk(detail_select, 32'h0);
      wrt(16'h00ca, 32'h0);
      wrt(16'h00c9, 32'h0);
      pwr();
      for (int i = 0; i < 4; i++) chk(slot(i), 32'h0);
   endtask : t_boot

   // each update class applies at its own moment
   task automatic t_classes;
      for (int i = 0; i < 4; i++)
         wrt(16'(16'h0100 + i), 32'(32'h11111111 * (i + 1)));
      @(posedge clock);
      #1;
      chk(slot(0), 32'h11111111);
      chk(slot(1) | slot(2) | slot(3), 32'h0);
      @(posedge clock);
      motion_stopped <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk(slot(1), 32'h22222222);
      wrt(16'h00c6, 32'h0);
      chk({31'h0, link_up}, 32'h0);
      chk({31'h0, busy}, 32'h1);
      repeat (15) @(posedge clock);
      #1;
      chk({31'h0, link_up}, 32'h0);
      @(posedge clock);
      #1;
      chk({31'h0, link_up}, 32'h1);
      chk(slot(2), 32'h33333333);
      chk(slot(3), 32'h0);
      wrt(16'h00c9, 32'h0);
      pwr();
      chk(slot(3), 32'h44444444);
   endtask : t_classes

   // link writes stay in work store until saved
   task automatic t_nv;
      wrt(16'h0100, 32'h5a5a5a5a);
      wrt(16'h00c8, 32'h0);
      repeat (3) @(posedge clock);
      #1;
      chk(slot(0), 32'h11111111);
      rdc(16'h0100, 32'h11111111);
   endtask : t_nv

   // both defaults commands
   task automatic t_defaults;
      wrt(16'h0103, 32'h00000077);
      wrt(16'h00c7, 32'h0);
      rdc(16'h0103, 32'h00000077);
      rdc(16'h0100, 32'h0);
      wrt(16'h00ca, 32'h0);
      rdc(16'h0103, 32'h0);
   endtask : t_defaults

   // every action strobe once, data ignored
   task automatic t_cmds;
      for (int i = 0; i < 13; i++)
      begin
         wrt(cmds[i], 32'hffffffff - i);
         chk(32'(actions), 32'h1 << (12 - i));
         @(posedge clock);
         #1;
         chk(32'(actions), 32'h0);
      end
   endtask : t_cmds

   // unknown ids do nothing
   task automatic t_unknown;
      wrt(16'h0101, 32'h22222222);
      wrt(16'h00c1, 32'h12345678);
      chk(32'(actions), 32'h0);
      wrt(16'h0104, 32'h87654321);
      rdc(16'h0104, 32'h0);
      rdc(16'h00c0, 32'h0);
      chk(slot(1), 32'h22222222);
   endtask : t_unknown

   // selector range and refusal
   task automatic t_select;
      wrt(16'h00d5, 32'h0000000a);
      rdc(16'h00d5, 32'h0000000a);
      wrt(16'h00d5, 32'h0000000b);
      chk(detail_select, 32'h0000000a);
      wrt(16'h00d5, 32'h0);
      chk(detail_select, 32'h0);
   endtask : t_select

   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   // watchdog
   initial
   begin
      #200000;
      n_errors++;
      wrap_up();
   end

   // main sequence
   initial
   begin
      t_boot();
      t_classes();
      t_nv();
      t_defaults();
      t_cmds();
      t_unknown();
      t_select();
      wrap_up();
   end
endmodule : psm_param_store_tb

`default_nettype wire
